// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
   logic clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, ev_go = 1'b0, tr_go = 1'b0;
   logic pready_out, pslverr_out, irq_out, rx_baud_tick_out, tx_baud_tick_out, event_input, trigger_pin;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rdata, n, r, rerr;
   int          n_errors = 0, samples_checked = 0, cyc = 0;
   tmr2_timer tmr2_timer_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .event_input_in(event_input),
      .trigger_pin_in(trigger_pin), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .irq_out(irq_out), .rx_baud_tick_out(rx_baud_tick_out), .tx_baud_tick_out(tx_baud_tick_out));
   tmr2_pins tmr2_pins_i (.clk_in(clk_in), .ev_go_in(ev_go), .tr_go_in(tr_go), .event_input_out(event_input),
      .trigger_pin_out(trigger_pin));
   initial forever #2 clk_in = ~clk_in;
   task automatic print_verdict;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1) @(posedge clk_in);
      rdata = prdata_out;
      rerr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdata & m, e);
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_errors = n_errors + 1;
         print_verdict;
      end
   end
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(tmr2_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
      rd(tmr2_pkg::ADDR_MODE, 32'hFF, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk(rerr, 32'h1);
      wr(tmr2_pkg::ADDR_RELOAD_LO, 32'hFE);
      wr(tmr2_pkg::ADDR_RELOAD_HI, 32'hFF);
      wr(tmr2_pkg::ADDR_COUNT_LO, 32'hFE);
      wr(tmr2_pkg::ADDR_COUNT_HI, 32'hFF);
      wr(tmr2_pkg::ADDR_IRQ_EN, 32'h1);
      wr(tmr2_pkg::ADDR_CTRL, 32'h04);
      repeat (60) @(posedge clk_in);
      rd(tmr2_pkg::ADDR_CTRL, 32'h80, 32'h80);
      rd(tmr2_pkg::ADDR_COUNT_HI, 32'hFF, 32'hFF);
      chk(irq_out, 32'h1);
      wr(tmr2_pkg::ADDR_CTRL, 32'h0);
      wr(tmr2_pkg::ADDR_CTRL, 32'h0);
      wr(tmr2_pkg::ADDR_COUNT_LO, 32'h0);
      wr(tmr2_pkg::ADDR_COUNT_HI, 32'h0);
      chk(irq_out, 32'h0);
      wr(tmr2_pkg::ADDR_CTRL, 32'h0D);
      tr_go <= 1'b1;
      @(posedge clk_in);
      tr_go <= 1'b0;
      repeat (40) @(posedge clk_in);
      rd(tmr2_pkg::ADDR_CTRL, 32'hC0, 32'h40);
      rd(tmr2_pkg::ADDR_RELOAD_HI, 32'hFF, 32'h0);
      wr(tmr2_pkg::ADDR_CTRL, 32'h0);
      wr(tmr2_pkg::ADDR_COUNT_LO, 32'h0);
      wr(tmr2_pkg::ADDR_CTRL, 32'h06);
      repeat (3) begin
         ev_go <= 1'b1;
         @(posedge clk_in);
         ev_go <= 1'b0;
         repeat (40) @(posedge clk_in);
      end
      rd(tmr2_pkg::ADDR_COUNT_LO, 32'hFF, 32'h3);
      wr(tmr2_pkg::ADDR_CTRL, 32'h0);
      wr(tmr2_pkg::ADDR_RELOAD_LO, 32'hF0);
      wr(tmr2_pkg::ADDR_RELOAD_HI, 32'hFF);
      wr(tmr2_pkg::ADDR_COUNT_LO, 32'hF0);
      wr(tmr2_pkg::ADDR_COUNT_HI, 32'hFF);
      wr(tmr2_pkg::ADDR_CTRL, 32'h14);
      n = 32'h0;
      r = 32'h0;
      repeat (1300) begin
         @(posedge clk_in);
         n = n + tx_baud_tick_out;
         r = r + rx_baud_tick_out;
      end
      chk(r, 32'h0);
      chk(n > 1, 32'h1);
      wr(tmr2_pkg::ADDR_CTRL, 32'h0);
      rd(tmr2_pkg::ADDR_CTRL, 32'h80, 32'h0);
      print_verdict;
   end
endmodule // tb

// ---- tmr2_chk.sv ----
`timescale 1ns/10ps
module tmr2_chk (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic irq_out,
   input wire logic rx_baud_tick_out,
   input wire logic tx_baud_tick_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_apb_answer: assert property (psel_in && penable_in |-> ##[0:16] pready_out) else $error("no ready");
   a_err_access: assert property (pslverr_out |-> psel_in && penable_in) else $error("stray err");
   a_err_idle: assert property (!psel_in |-> !pslverr_out) else $error("idle err");
   a_irq_start: assert property ($fell(rst_in) |-> !irq_out [*8]) else $error("irq at start");
   a_tick_start: assert property ($fell(rst_in) |-> !(rx_baud_tick_out || tx_baud_tick_out) [*8])
      else $error("tick at start");
   a_rx_gap: assert property (rx_baud_tick_out |=> !rx_baud_tick_out [*8]) else $error("rx gap");
   a_tx_gap: assert property (tx_baud_tick_out |=> !tx_baud_tick_out [*8]) else $error("tx gap");
   a_irq_held: assert property ($rose(irq_out) && !psel_in |=> irq_out) else $error("irq dropped");
endmodule // tmr2_chk
bind tmr2_timer tmr2_chk tmr2_chk_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
   .rx_baud_tick_out(rx_baud_tick_out), .tx_baud_tick_out(tx_baud_tick_out));

// ---- tmr2_edge.sv ----
`timescale 1ns/10ps
module tmr2_edge (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       event_input_in,
   input  wire logic       trigger_pin_in,
   tmr2_edge_if.edge_unit  eif
);
   logic evt_s_q;
   logic trg_s_q;
   logic evt_pend_q;
   logic trg_pend_q;
   logic evt_fall_q;
   logic trg_fall_q;

   // Pins are looked at only in the sample phase, so an edge needs two machine cycles to be seen.
   wire evt_seen = eif.sample_en & evt_s_q & ~event_input_in;
   wire trg_seen = eif.sample_en & trg_s_q & ~trigger_pin_in;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         evt_s_q    <= 1'b0;
         trg_s_q    <= 1'b0;
         evt_pend_q <= 1'b0;
         trg_pend_q <= 1'b0;
         evt_fall_q <= 1'b0;
         trg_fall_q <= 1'b0;
      end else begin
         if (eif.sample_en) begin
            evt_s_q <= event_input_in;
            trg_s_q <= trigger_pin_in;
         end
         evt_pend_q <= evt_seen | (evt_pend_q & ~eif.update_en);
         trg_pend_q <= trg_seen | (trg_pend_q & ~eif.update_en);
         evt_fall_q <= eif.update_en & evt_pend_q;
         trg_fall_q <= eif.update_en & trg_pend_q;
      end
   end

   assign eif.event_fall = evt_fall_q;
   assign eif.trig_fall  = trg_fall_q;
   assign eif.trig_level = trg_s_q;
endmodule // tmr2_edge

// ---- tmr2_edge_if.sv ----
`timescale 1ns/10ps
interface tmr2_edge_if;
   logic sample_en;
   logic update_en;
   logic event_fall;
   logic trig_fall;
   logic trig_level;
   modport timer (output sample_en, output update_en, input event_fall, input trig_fall, input trig_level);
   modport edge_unit (input sample_en, input update_en, output event_fall, output trig_fall, output trig_level);
endinterface

// ---- tmr2_pins.sv ----
`timescale 1ns/10ps
module tmr2_pins (
   input  wire logic clk_in,
   input  wire logic ev_go_in,
   input  wire logic tr_go_in,
   output logic      event_input_out,
   output logic      trigger_pin_out
);
   logic [4:0] ev_q = 5'h00;
   logic [4:0] tr_q = 5'h00;
   // Each low lasts sixteen clocks, over one machine cycle, so no level is missed.
   always_ff @(posedge clk_in) begin
      ev_q <= ev_go_in ? 5'h1F : ev_q - {4'h0, ev_q != 5'h00};
      tr_q <= tr_go_in ? 5'h1F : tr_q - {4'h0, tr_q != 5'h00};
   end
   assign event_input_out = !ev_q[4];
   assign trigger_pin_out = !tr_q[4];
endmodule // tmr2_pins

// ---- tmr2_pkg.sv ----
package tmr2_pkg;
   localparam logic [7:0]  ADDR_CTRL       = 8'hC8;
   localparam logic [7:0]  ADDR_MODE       = 8'hCC;
   localparam logic [7:0]  ADDR_RELOAD_LO  = 8'hD0;
   localparam logic [7:0]  ADDR_RELOAD_HI  = 8'hD4;
   localparam logic [7:0]  ADDR_COUNT_LO   = 8'hD8;
   localparam logic [7:0]  ADDR_COUNT_HI   = 8'hDC;
   localparam logic [7:0]  ADDR_IRQ_EN     = 8'hE0;
   localparam int          BIT_OVF         = 7;
   localparam int          BIT_EXT         = 6;
   localparam int          BIT_RCLK        = 5;
   localparam int          BIT_TX_CLOCK_SELECT        = 4;
   localparam int          BIT_EXEN        = 3;
   localparam int          BIT_RUN         = 2;
   localparam int          BIT_CSRC        = 1;
   localparam int          BIT_CPRL        = 0;
   localparam int          BIT_DOWN_COUNT_ENABLE        = 0;
   localparam int          BIT_IRQ_EN      = 0;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [15:0] COUNT_RESET     = 16'h0000;
   localparam logic [15:0] COUNT_TOP       = 16'hFFFF;
   localparam logic [3:0]  PHASES_PER_MC   = 4'hC;
   localparam logic [3:0]  SAMPLE_PHASE    = 4'h9;
   localparam logic [3:0]  UPDATE_PHASE    = 4'h4;
   localparam logic [3:0]  BAUD_DIVIDE     = 4'hF;
   typedef enum logic [3:0] {
      TMR2_OFF     = 4'b0001,
      TMR2_CAPTURE = 4'b0010,
      TMR2_RELOAD  = 4'b0100,
      TMR2_BAUD    = 4'b1000
   } tmr2_mode_e;
endpackage

// ---- tmr2_timer.sv ----
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/10ps
module tmr2_timer (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic        event_input_in,
   input  wire logic        trigger_pin_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic             irq_out,
   output logic             rx_baud_tick_out,
   output logic             tx_baud_tick_out
);
   // ****************************************
   // Phase divider
   // ****************************************
   tmr2_edge_if eif ();

   logic [3:0]  phase_q;
   logic        sample_q;
   logic        update_q;

   wire         last_phase = (phase_q == (tmr2_pkg::PHASES_PER_MC - 4'h1));
   wire [3:0]   phase_d    = last_phase ? 4'h0 : phase_q + 4'h1;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         phase_q  <= 4'h0;
         sample_q <= 1'b0;
         update_q <= 1'b0;
      end else begin
         phase_q  <= phase_d;
         sample_q <= (phase_d == tmr2_pkg::SAMPLE_PHASE);
         update_q <= (phase_d == tmr2_pkg::UPDATE_PHASE);
      end
   end

   assign eif.sample_en = sample_q;
   assign eif.update_en = update_q;

   tmr2_edge u_edge (
      .clk_in         (clk_in),
      .rst_in         (rst_in),
      .event_input_in (event_input_in),
      .trigger_pin_in (trigger_pin_in),
      .eif            (eif)
   );

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0]  ctrl_q;
   logic        down_count_enable_q;
   logic        irq_en_q;
   logic [15:0] reload_q;
   logic [15:0] count_q;
   logic [3:0]  baud_div_q;

   wire ovf_flag   = ctrl_q[tmr2_pkg::BIT_OVF];
   wire ext_flag   = ctrl_q[tmr2_pkg::BIT_EXT];
   wire rx_sel     = ctrl_q[tmr2_pkg::BIT_RCLK];
   wire tx_sel     = ctrl_q[tmr2_pkg::BIT_TX_CLOCK_SELECT];
   wire exen       = ctrl_q[tmr2_pkg::BIT_EXEN];
   wire run        = ctrl_q[tmr2_pkg::BIT_RUN];
   wire csrc       = ctrl_q[tmr2_pkg::BIT_CSRC];
   wire cprl       = ctrl_q[tmr2_pkg::BIT_CPRL];

   // ****************************************
   // Mode decode
   // ****************************************
   wire         baud_sel = rx_sel | tx_sel;
   tmr2_pkg::tmr2_mode_e mode;

   // Baud selection overrides the capture/reload select, which is ignored then.
   assign mode = !run     ? tmr2_pkg::TMR2_OFF     :
                 baud_sel ? tmr2_pkg::TMR2_BAUD    :
                 cprl     ? tmr2_pkg::TMR2_CAPTURE :
                            tmr2_pkg::TMR2_RELOAD;

   // ****************************************
   // Bus side
   // ****************************************
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic        irq_q;
   logic        rx_tick_q;
   logic        tx_tick_q;
   logic        state_q;

   wire         bus_access = psel_in & penable_in;
   wire         bus_commit = bus_access & pready_q;
   wire         bus_wr     = bus_commit & pwrite_in;
   wire         bus_first  = bus_access & ~pready_q;
   wire [7:0]   wbyte      = pwdata_in[7:0];

   wire         hit_ctrl   = (paddr_in == tmr2_pkg::ADDR_CTRL);
   wire         hit_mode   = (paddr_in == tmr2_pkg::ADDR_MODE);
   wire         hit_rl_lo  = (paddr_in == tmr2_pkg::ADDR_RELOAD_LO);
   wire         hit_rl_hi  = (paddr_in == tmr2_pkg::ADDR_RELOAD_HI);
   wire         hit_cnt_lo = (paddr_in == tmr2_pkg::ADDR_COUNT_LO);
   wire         hit_cnt_hi = (paddr_in == tmr2_pkg::ADDR_COUNT_HI);
   wire         hit_irq_en = (paddr_in == tmr2_pkg::ADDR_IRQ_EN);
   wire         hit_known  = hit_ctrl
                           | hit_mode
                           | hit_rl_lo
                           | hit_rl_hi
                           | hit_cnt_lo
                           | hit_cnt_hi
                           | hit_irq_en;

   // Replaces one byte of a sixteen-bit pair.
   function automatic logic [15:0] put_byte(
      input logic [15:0] word,
      input logic        high,
      input logic [7:0]  value
   );
      put_byte = high ? {value, word[7:0]} : {word[15:8], value};
   endfunction

   // ****************************************
   // Count step
   // ****************************************
   // Timer ticks come from the phase divider (in baud mode from state_q, every second clock), counter ticks from the edge unit.
   wire         slow_tick  = csrc ? eif.event_fall : update_q;
   wire         fast_tick  = csrc ? eif.event_fall : state_q;
   wire         trig_evt   = exen & eif.trig_fall;
   wire         count_up   = ~down_count_enable_q | eif.trig_level;
   wire         at_top     = (count_q == tmr2_pkg::COUNT_TOP);
   wire         at_reload  = (count_q == reload_q);
   wire [15:0]  count_inc  = count_q + 16'h0001;
   wire [15:0]  count_dec  = count_q - 16'h0001;

   logic [15:0] next_count;
   logic [15:0] next_reload;
   logic        set_ovf;
   logic        set_ext;
   logic        roll;

   always_comb begin
      next_count  = count_q;
      next_reload = reload_q;
      set_ovf     = 1'b0;
      set_ext     = 1'b0;
      roll        = 1'b0;
      case (mode)
         tmr2_pkg::TMR2_CAPTURE: begin
            if (slow_tick) begin
               next_count = count_inc;
               set_ovf    = at_top;
            end
            if (trig_evt) begin
               next_reload = count_q;
               set_ext     = 1'b1;
            end
         end
         tmr2_pkg::TMR2_RELOAD: begin
            if (slow_tick && count_up && at_top) begin
               next_count = reload_q;
               set_ovf    = 1'b1;
            end else if (slow_tick && count_up) begin
               next_count = count_inc;
            end else if (slow_tick && at_reload) begin
               next_count = tmr2_pkg::COUNT_TOP;
               set_ovf    = 1'b1;
            end else if (slow_tick) begin
               next_count = count_dec;
            end
            // With down-counting the trigger pin is a direction level, not an event.
            if (trig_evt && !down_count_enable_q) begin
               next_count = reload_q;
               set_ext    = 1'b1;
            end
         end
         tmr2_pkg::TMR2_BAUD: begin
            if (fast_tick && at_top) begin
               next_count = reload_q;
               roll       = 1'b1;
            end else if (fast_tick) begin
               next_count = count_inc;
            end
            if (trig_evt) begin
               set_ext = 1'b1;
            end
         end
         default: begin
            next_count = count_q;
         end
      endcase
   end

   // ****************************************
   // Register next values
   // ****************************************
   // Software writes land first; a hardware flag set in the same cycle wins.
   wire [7:0]   ctrl_w     = (bus_wr && hit_ctrl) ? wbyte : ctrl_q;
   logic [7:0]  ctrl_d;

   always_comb begin
      ctrl_d = ctrl_w;
      if (set_ovf && !baud_sel) begin
         ctrl_d[tmr2_pkg::BIT_OVF] = 1'b1;
      end
      if (set_ext) begin
         ctrl_d[tmr2_pkg::BIT_EXT] = 1'b1;
      end
   end

   wire [15:0]  count_w    = (bus_wr && hit_cnt_lo) ? put_byte(next_count, 1'b0, wbyte) : next_count;
   wire [15:0]  count_d    = (bus_wr && hit_cnt_hi) ? put_byte(count_w, 1'b1, wbyte) : count_w;
   wire [15:0]  reload_w   = (bus_wr && hit_rl_lo) ? put_byte(next_reload, 1'b0, wbyte) : next_reload;
   wire [15:0]  reload_d   = (bus_wr && hit_rl_hi) ? put_byte(reload_w, 1'b1, wbyte) : reload_w;

   // ****************************************
   // Baud divider
   // ****************************************
   // One divider serves both directions; each select only gates its own tick.
   wire         div_wrap   = roll & (baud_div_q == tmr2_pkg::BAUD_DIVIDE);
   wire [3:0]   baud_div_d = roll ? baud_div_q + 4'h1 : baud_div_q;
   wire         rx_tick_d  = div_wrap & rx_sel;
   wire         tx_tick_d  = div_wrap & tx_sel;

   // ****************************************
   // Read data and interrupt
   // ****************************************
   wire [7:0]   rd_byte    = hit_ctrl   ? ctrl_q :
                             hit_mode   ? {7'h00, down_count_enable_q} :
                             hit_rl_lo  ? reload_q[7:0] :
                             hit_rl_hi  ? reload_q[15:8] :
                             hit_cnt_lo ? count_q[7:0] :
                             hit_cnt_hi ? count_q[15:8] :
                             hit_irq_en ? {7'h00, irq_en_q} :
                                          8'h00;
   wire         irq_d      = irq_en_q & (ovf_flag | (ext_flag & ~down_count_enable_q));

   // ****************************************
   // Timer registers
   // ****************************************
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q     <= tmr2_pkg::CTRL_RESET;
         down_count_enable_q     <= 1'b0;
         irq_en_q   <= 1'b0;
         reload_q   <= tmr2_pkg::COUNT_RESET;
         count_q    <= tmr2_pkg::COUNT_RESET;
         baud_div_q <= 4'h0;
         state_q    <= 1'b0;
      end else begin
         ctrl_q     <= ctrl_d;
         reload_q   <= reload_d;
         count_q    <= count_d;
         baud_div_q <= baud_div_d;
         state_q    <= ~state_q;
         if (bus_wr && hit_mode) begin
            down_count_enable_q <= pwdata_in[tmr2_pkg::BIT_DOWN_COUNT_ENABLE];
         end
         if (bus_wr && hit_irq_en) begin
            irq_en_q <= pwdata_in[tmr2_pkg::BIT_IRQ_EN];
         end
      end
   end

   // ****************************************
   // Output registers
   // ****************************************
   // The slave answers one cycle into the access phase, with data already registered.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
         irq_q     <= 1'b0;
         rx_tick_q <= 1'b0;
         tx_tick_q <= 1'b0;
      end else begin
         pready_q  <= bus_first;
         pslverr_q <= bus_first & ~hit_known;
         if (bus_first) begin
            prdata_q <= {24'h000000, rd_byte};
         end
         irq_q     <= irq_d;
         rx_tick_q <= rx_tick_d;
         tx_tick_q <= tx_tick_d;
      end
   end

   assign prdata_out       = prdata_q;
   assign pready_out       = pready_q;
   assign pslverr_out      = pslverr_q;
   assign irq_out          = irq_q;
   assign rx_baud_tick_out = rx_tick_q;
   assign tx_baud_tick_out = tx_tick_q;
endmodule // tmr2_timer
